// ---- dv/tb_top.sv ----
/*
 Self-checking bench for the aux clock, tone and repeater block.
 Assumes mclk stands for the VCO clock and both bus sides are pulled up.
*/
`timescale 1ns/10ps
module tb_top;
    typedef struct {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    logic                 mclk, rst, sclHost, sdaHostDrv, tunerCmd;
    aux_clk_pkg::regReq_t req;
    logic [7:0]           rdData_q;
    logic                 auxClk_q, tone_q, sdaHostOut_q, sdaHostOe_q;
    logic                 sclTunerOut_q, sclTunerOe_q, tunerPull_q;
    logic                 sdaTunerOut_q, sdaTunerOe_q;
    int                   fail_count, checks;
    // Pull-ups: a released line reads 1
    wire logic hostLine  = (sdaHostOe_q ? sdaHostOut_q : 1'b1) & sdaHostDrv;
    wire logic sclLine   = sclTunerOe_q ? sclTunerOut_q : 1'b1;
    wire logic tunerLine = (sdaTunerOe_q ? sdaTunerOut_q : 1'b1) &
                           ~tunerPull_q;
    row_t rows[8] = '{'{0, 8'h03, 8'h00, 8'h2a}, '{0, 8'h04, 8'h00, 8'h8e},
        '{0, 8'h05, 8'h00, 8'h0f}, '{0, 8'h02, 8'h00, 8'h34},
        '{1, 8'h06, 8'hff, 8'h00}, '{1, 8'h03, 8'h55, 8'h55},
        '{1, 8'h04, 8'h12, 8'h12}, '{1, 8'h05, 8'hb5, 8'hb5}};

    aux_clock_tone_and_repeater_cfg DUT (.mclk(mclk), .rst(rst),
        .regReq(req), .rdData_q(rdData_q), .auxClk_q(auxClk_q),
        .tone_q(tone_q), .sclHostIn(sclHost), .sdaHostIn(hostLine),
        .sdaHostOut_q(sdaHostOut_q), .sdaHostOe_q(sdaHostOe_q),
        .sdaTunerIn(tunerLine), .sclTunerOut_q(sclTunerOut_q),
        .sclTunerOe_q(sclTunerOe_q), .sdaTunerOut_q(sdaTunerOut_q),
        .sdaTunerOe_q(sdaTunerOe_q));
    tuner_model TUNER (.mclk(mclk), .sclLine(sclLine), .pullCmd(tunerCmd),
        .sdaPull_q(tunerPull_q));

    always #5 mclk = ~mclk;

    task print_verdict;
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        req = '{1'b1, 1'b0, a, d};
        step(1);
        req = '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        step(1);
        req = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        req = '0;
        chk(rdData_q, e);
    endtask
    function logic sig(input bit s);
        return s ? tone_q : auxClk_q;
    endfunction
    // Period and high time, measured from a rising edge
    task meas(input bit s, input int per, input int hi);
        int n;
        int h;
        n = 0;
        h = 0;
        while (sig(s) !== 1'b0 && n < 3000)
        begin
            step(1);
            n++;
        end
        while (sig(s) !== 1'b1 && n < 3000)
        begin
            step(1);
            n++;
        end
        while (sig(s) === 1'b1 && h < 3000)
        begin
            step(1);
            h++;
        end
        n = h;
        while (sig(s) === 1'b0 && n < 3000)
        begin
            step(1);
            n++;
        end
        chk(h[15:0], hi[15:0]);
        chk(n[15:0], per[15:0]);
    endtask

    initial
    begin
        // Far longer than the whole sequence needs
        #600000;
        fail_count++;
        $display("wrong value at %0t: timeout", $time);
        print_verdict;
    end

    initial
    begin
        logic v;
        mclk = 1'b0;
        rst = 1'b1;
        req = '0;
        sclHost = 1'b1;
        sdaHostDrv = 1'b1;
        tunerCmd = 1'b0;
        fail_count = 0;
        checks = 0;
        step(3);
        rst = 1'b0;
        step(1);
        chk(auxClk_q, 0);
        chk(tone_q, 0);
        chk({sclLine, tunerLine}, 2'b11);
        foreach (rows[i])
        begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(8'h03, 8'h01);
        step(3);
        chk(auxClk_q, 1);
        wr(8'h03, 8'h1e);
        step(3);
        chk(auxClk_q, 0);
        wr(8'h03, 8'h22);
        meas(0, 16, 8);
        wr(8'h03, 8'h21);
        meas(0, 8, 4);
        step(2);
        wr(8'h03, 8'h3f);
        chk(auxClk_q, 0);
        // A rewrite in the high half must bring back the low half
        step(130);
        chk(auxClk_q, 1);
        wr(8'h03, 8'h3f);
        step(2);
        chk(auxClk_q, 0);
        step(100);
        chk(auxClk_q, 0);
        wr(8'h04, 8'h04);
        meas(1, 512, 256);
        wr(8'h04, 8'h03);
        meas(1, 384, 256);
        // LF periods are too long to measure; it must stay low a long while
        wr(8'h03, 8'h40);
        step(200);
        chk(auxClk_q, 0);
        // Freeze mid-cycle; 24 cycles would flip a running output
        wr(8'h03, 8'h22);
        step(5);
        wr(8'h02, 8'h74);
        v = auxClk_q;
        step(24);
        chk(auxClk_q, v);
        wr(8'h02, 8'h34);
        meas(0, 16, 8);
        wr(8'h05, 8'h04);
        step(2);
        chk({sclLine, tunerLine}, 2'b10);
        wr(8'h05, 8'h80);
        sclHost = 1'b0;
        step(3);
        chk(sclLine, 0);
        sclHost = 1'b1;
        sdaHostDrv = 1'b0;
        step(3);
        chk({sclLine, tunerLine}, 2'b10);
        sdaHostDrv = 1'b1;
        step(3);
        chk(tunerLine, 1);
        sclHost = 1'b0;
        tunerCmd = 1'b1;
        step(4);
        chk(hostLine, 0);
        tunerCmd = 1'b0;
        step(4);
        chk(hostLine, 1);
        sclHost = 1'b1;
        // Reset in mid-run with the repeater active
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        step(1);
        chk({sclLine, tunerLine}, 2'b11);
        chk(auxClk_q, 0);
        chk(tone_q, 0);
        rd(8'h05, 8'h0f);
        rd(8'h02, 8'h34);
        print_verdict;
    end
endmodule // tb_top

// ---- dv/tuner_model.sv ----
/*
 Tuner on the repeated two-wire bus; pulls its data line low on command.
 Assumes the bench resolves the bus levels and feeds back the clock line.
*/
`timescale 1ns/10ps
module tuner_model
(
    // Clock
    input  wire logic mclk,
    // Bus level and command
    input  wire logic sclLine,
    input  wire logic pullCmd,
    output logic      sdaPull_q
);
    initial sdaPull_q = 1'b0;
    // A slave only changes data while the clock line is low
    always @(posedge mclk)
    begin
        if (!sclLine)
            sdaPull_q <= pullCmd;
    end
endmodule // tuner_model

// ---- rtl/aux_clk_pkg.sv ----
/*
 Constants, register map and carrier types for the auxiliary clock,
 tone divider and tuner bus repeater configuration block.
 Assumes a serial register front end delivering single-byte accesses.
*/
package aux_clk_pkg;
    localparam logic [7:0] ADDR_MCLK     = 8'h02;
    localparam logic [7:0] ADDR_AUXCFG   = 8'h03;
    localparam logic [7:0] ADDR_TONEDIV  = 8'h04;
    localparam logic [7:0] ADDR_RPTCTL   = 8'h05;
    localparam logic [7:0] RST_MCLK      = 8'h34;
    localparam logic [7:0] RST_AUXCFG    = 8'h2a;
    localparam logic [7:0] RST_TONEDIV   = 8'h8e;
    localparam logic [7:0] RST_RPTCTL    = 8'h0f;
    localparam int         VCO_OFF_BIT   = 6;
    localparam int         SEL_HI        = 7;
    localparam int         SEL_LO        = 5;
    localparam int         DIV_HI        = 4;
    localparam int         PORT_BIT      = 0;
    localparam int         RPT_MODE_BIT  = 7;
    localparam int         TUN_CLK_BIT   = 2;
    localparam int         TUN_DATA_BIT  = 0;
    localparam logic [2:0] SEL_PORT      = 3'h0;
    localparam logic [2:0] SEL_HF        = 3'h1;
    localparam logic [2:0] PRE8_LAST     = 3'h7;
    localparam logic [3:0] SH16_LAST     = 4'hf;
    localparam logic [3:0] PRE_SHIFT     = 4'h4;
    localparam logic [7:0] LF_BASE       = 8'h20;
    localparam logic [7:0] RD_NONE       = 8'h00;

    typedef enum logic [1:0] {AUX_PORT, AUX_HF, AUX_LF} auxMode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } regReq_t;
endpackage

// ---- rtl/aux_clock_tone_and_repeater_cfg.sv ----
/*
 Auxiliary clock generator, tone divider and tuner-side bus repeater
 or static port, with their configuration registers.
 Assumes mclk stands for the VCO clock and that register requests come
 synchronous to it from the serial register front end.
*/
`timescale 1ns/10ps
module aux_clock_tone_and_repeater_cfg
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // Register access
    input  wire aux_clk_pkg::regReq_t regReq,
    output logic [7:0]              rdData_q,
    // Generated clocks
    output logic                    auxClk_q,
    output logic                    tone_q,
    // Host-side bus pins
    input  wire logic               sclHostIn,
    input  wire logic               sdaHostIn,
    output logic                    sdaHostOut_q,
    output logic                    sdaHostOe_q,
    // Tuner-side bus pins
    input  wire logic               sdaTunerIn,
    output logic                    sclTunerOut_q,
    output logic                    sclTunerOe_q,
    output logic                    sdaTunerOut_q,
    output logic                    sdaTunerOe_q
);
    logic [7:0]  mclkCfg_q;
    logic [7:0]  auxCfg_q;
    logic [7:0]  toneDiv_q;
    logic [7:0]  rptCtl_q;
    logic [2:0]  pre8_q;
    logic [3:0]  sh16_q;
    logic [10:0] preCnt_q;
    logic [7:0]  auxCnt_q;
    logic [7:0]  toneCnt_q;

    wire         vcoRun  = ~mclkCfg_q[aux_clk_pkg::VCO_OFF_BIT];
    wire         wrAux   = regReq.wr &&
                           regReq.addr == aux_clk_pkg::ADDR_AUXCFG;
    wire         wrTone  = regReq.wr &&
                           regReq.addr == aux_clk_pkg::ADDR_TONEDIV;
    wire [2:0]   sel     = auxCfg_q[aux_clk_pkg::SEL_HI:aux_clk_pkg::SEL_LO];
    wire [4:0]   divN    = auxCfg_q[aux_clk_pkg::DIV_HI:0];
    wire aux_clk_pkg::auxMode_t mode = aux_clk_pkg::auxMode_t'(
        (sel == aux_clk_pkg::SEL_PORT) ? aux_clk_pkg::AUX_PORT :
        (sel == aux_clk_pkg::SEL_HF)   ? aux_clk_pkg::AUX_HF :
                                         aux_clk_pkg::AUX_LF);
    wire         tick8   = vcoRun && pre8_q == aux_clk_pkg::PRE8_LAST;
    // Shared divide-by-16 feeds both the tone and the LF prescaler
    wire         tick16  = tick8 &&
                           sh16_q == aux_clk_pkg::SH16_LAST;
    wire [11:0]  preSpan = 12'h001 << (4'(sel) + aux_clk_pkg::PRE_SHIFT);
    wire [10:0]  preLast = 11'(preSpan - 12'h001);
    wire         preDone = tick16 && preCnt_q == preLast;
    // HF counts raw VCO cycles over 8N so the wave is exactly square
    wire [7:0]   auxDiv  = (mode == aux_clk_pkg::AUX_HF) ? {divN, 3'h0} :
                           aux_clk_pkg::LF_BASE + 8'(divN);
    wire         auxStep = (mode == aux_clk_pkg::AUX_HF) ? vcoRun : preDone;
    wire         auxWrap = auxCnt_q >= auxDiv - 8'h01;
    wire         toneWrap = toneCnt_q >= toneDiv_q - 8'h01;
    wire         rptMode = rptCtl_q[aux_clk_pkg::RPT_MODE_BIT];
    wire [7:0]   rdMux   =
        (regReq.addr == aux_clk_pkg::ADDR_MCLK)    ? mclkCfg_q :
        (regReq.addr == aux_clk_pkg::ADDR_AUXCFG)  ? auxCfg_q  :
        (regReq.addr == aux_clk_pkg::ADDR_TONEDIV) ? toneDiv_q :
        (regReq.addr == aux_clk_pkg::ADDR_RPTCTL)  ? rptCtl_q  :
                                                     aux_clk_pkg::RD_NONE;

    // Registers; bits marked as must-be-zero are kept as written
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mclkCfg_q <= aux_clk_pkg::RST_MCLK;
            auxCfg_q  <= aux_clk_pkg::RST_AUXCFG;
            toneDiv_q <= aux_clk_pkg::RST_TONEDIV;
            rptCtl_q  <= aux_clk_pkg::RST_RPTCTL;
            rdData_q  <= aux_clk_pkg::RD_NONE;
        end
        else
        begin
            if (regReq.wr && regReq.addr == aux_clk_pkg::ADDR_MCLK)
                mclkCfg_q <= regReq.data;
            if (wrAux)
                auxCfg_q <= regReq.data;
            if (wrTone)
                toneDiv_q <= regReq.data;
            if (regReq.wr && regReq.addr == aux_clk_pkg::ADDR_RPTCTL)
                rptCtl_q <= regReq.data;
            if (regReq.rd)
                rdData_q <= rdMux;
        end
    end

    // Common prescale stages; they free-run so one write never upsets
    // the other generator
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pre8_q <= 3'h0;
            sh16_q <= 4'h0;
        end
        else
        begin
            if (vcoRun)
                pre8_q <= pre8_q + 3'h1;
            if (tick8)
                sh16_q <= sh16_q + 4'h1;
        end
    end

    // Auxiliary generator
    always_ff @(posedge mclk)
    begin
        if (rst || wrAux)
        begin
            preCnt_q <= 11'h000;
            auxCnt_q <= 8'h00;
        end
        else
        begin
            if (tick16)
                preCnt_q <= preDone ? 11'h000 : preCnt_q + 11'h001;
            if (auxStep)
                auxCnt_q <= auxWrap ? 8'h00 : auxCnt_q + 8'h01;
        end
    end

    // Low for the first half-period, high for the second
    always_ff @(posedge mclk)
    begin
        if (rst)
            auxClk_q <= 1'b0;
        else if (mode == aux_clk_pkg::AUX_PORT)
            auxClk_q <= auxCfg_q[aux_clk_pkg::PORT_BIT];
        else
            auxClk_q <= auxDiv != 8'h00 &&
                        auxCnt_q >= (auxDiv >> 1);
    end

    // Tone generator; a zero divider parks the output low
    always_ff @(posedge mclk)
    begin
        if (rst || wrTone)
        begin
            toneCnt_q <= 8'h00;
            tone_q    <= 1'b0;
        end
        else
        begin
            if (tick16)
                toneCnt_q <= toneWrap ? 8'h00 : toneCnt_q + 8'h01;
            tone_q <= toneDiv_q != 8'h00 &&
                      toneCnt_q >= (toneDiv_q >> 1);
        end
    end

    // Repeater: on the data line each side pulls the other low unless it is
    // itself echoing a low, which breaks the latch-up loop; the clock goes host to tuner only
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sclTunerOut_q <= 1'b0;
            sclTunerOe_q  <= 1'b0;
            sdaTunerOut_q <= 1'b0;
            sdaTunerOe_q  <= 1'b0;
            sdaHostOut_q  <= 1'b0;
            sdaHostOe_q   <= 1'b0;
        end
        else if (rptMode)
        begin
            sclTunerOut_q <= 1'b0;
            sclTunerOe_q  <= ~sclHostIn;
            sdaTunerOut_q <= 1'b0;
            sdaTunerOe_q  <= ~sdaHostIn && ~sdaHostOe_q;
            sdaHostOut_q  <= 1'b0;
            sdaHostOe_q   <= ~sdaTunerIn && ~sdaTunerOe_q;
        end
        else
        begin
            sclTunerOut_q <= rptCtl_q[aux_clk_pkg::TUN_CLK_BIT];
            sclTunerOe_q  <= 1'b1;
            sdaTunerOut_q <= rptCtl_q[aux_clk_pkg::TUN_DATA_BIT];
            sdaTunerOe_q  <= 1'b1;
            sdaHostOut_q  <= 1'b0;
            sdaHostOe_q   <= 1'b0;
        end
    end

    property p_staticPort;
        @(posedge mclk) disable iff (rst)
        sel == 3'h0 |=> auxClk_q == $past(auxCfg_q[0]);
    endproperty
    a_staticPort: assert property (p_staticPort)
        else $error("static aux port level wrong");

    property p_tick8Spacing;
        @(posedge mclk) disable iff (rst)
        tick8 |=> !tick8 [*7];
    endproperty
    a_tick8Spacing: assert property (p_tick8Spacing)
        else $error("divide by 8 stage fires too often");

    property p_toneSteady;
        @(posedge mclk) disable iff (rst)
        (!tick16 && !wrTone) ##1 (!tick16 && !wrTone) |=> $stable(tone_q);
    endproperty
    a_toneSteady: assert property (p_toneSteady)
        else $error("tone changed without a divider step");

    property p_toneRate;
        @(posedge mclk) disable iff (rst)
        tick16 |=> !tick16 [*8] ##0 !tick16;
    endproperty
    a_toneRate: assert property (p_toneRate)
        else $error("shared divide by 16 too fast");

    property p_portMode;
        @(posedge mclk) disable iff (rst)
        !rptMode |=> sclTunerOe_q && sdaTunerOe_q &&
                     sclTunerOut_q == $past(rptCtl_q[2]);
    endproperty
    a_portMode: assert property (p_portMode)
        else $error("tuner pins not driven as port");

    property p_repeatLow;
        @(posedge mclk) disable iff (rst)
        rptMode && !sclHostIn |=> sclTunerOe_q && !sclTunerOut_q;
    endproperty
    a_repeatLow: assert property (p_repeatLow)
        else $error("host clock low not repeated");

    property p_vcoStop;
        @(posedge mclk) disable iff (rst)
        !vcoRun |=> $stable(pre8_q) && $stable(sh16_q);
    endproperty
    a_vcoStop: assert property (p_vcoStop)
        else $error("dividers run with VCO stopped");

    property p_restart;
        @(posedge mclk) disable iff (rst)
        wrAux |=> preCnt_q == 11'h000 && auxCnt_q == 8'h00;
    endproperty
    a_restart: assert property (p_restart)
        else $error("aux counters not restarted on write");

    property p_lfStep;
        @(posedge mclk) disable iff (rst)
        mode == aux_clk_pkg::AUX_LF && !preDone && !wrAux |=>
            $stable(auxCnt_q);
    endproperty
    a_lfStep: assert property (p_lfStep)
        else $error("LF divider stepped between prescaler ticks");
endmodule // aux_clock_tone_and_repeater_cfg
